// >>> logic/tltp_consts.vh
`ifndef TLTP_CONSTS_VH
`define TLTP_CONSTS_VH

// Torque value width and control mode codes
`define TLTP_TW 16
`define TLTP_CM_POS 2'h0
`define TLTP_CM_SPD 2'h1
`define TLTP_CM_TRQ 2'h2

// Torque limit mode settings, legal range and default
`define TLTP_TLM_PRI_BOTH 3'h1
`define TLTP_TLM_PRI_SEC 3'h2
`define TLTP_TLM_INPUT_SW 3'h3
`define TLTP_TLM_NET_MIN 3'h4
`define TLTP_TLM_NET_SW 3'h5
`define TLTP_TLM_MIN 3'h1
`define TLTP_TLM_MAX 3'h5
`define TLTP_TLM_DEFAULT 3'h1

// Travel prohibit mode settings, legal range and default
`define TLTP_TPM_STOP 2'h0
`define TLTP_TPM_IGNORE 2'h1
`define TLTP_TPM_ALARM 2'h2
`define TLTP_TPM_MAX 2'h2
`define TLTP_TPM_DEFAULT 2'h0

// Alarm code raised by travel prohibit faults
`define TLTP_ALARM_CODE 8'h26
`define TLTP_ALARM_NONE 8'h00

// Stop sequence select width
`define TLTP_SW 4

// Synchroniser reset level; prohibit pins are high while closed
`define TLTP_SYNC_RST 1'b0
`define TLTP_PIN_IDLE 1'b1

`endif

// >>> logic/tltp_min.v
`default_nettype none

module tltp_min #(
   parameter WIDTH = 16
) (
   input wire [WIDTH-1:0] a,
   input wire [WIDTH-1:0] b,
   output wire [WIDTH-1:0] smaller
);
   // Unsigned magnitude compare; ties take a
   assign smaller = (b < a) ? b : a;
endmodule // tltp_min

`default_nettype wire

// >>> logic/tltp_sync.v
`default_nettype none

module tltp_sync #(
   parameter WIDTH = 1,
   parameter [0:0] RST_VAL = 1'b0
) (
   input wire clk,
   input wire arst_n,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : gBit
         reg stage1;
         reg stage2;
         always @(posedge clk or negedge arst_n)
         begin
            // Reset level matches the idle level of the pin behind it
            if (!arst_n)
            begin
               stage1 <= RST_VAL;
               stage2 <= RST_VAL;
            end
            else
            begin
               stage1 <= asyncIn[i];
               stage2 <= stage1;
            end
         end
         assign syncOut[i] = stage2;
      end
   endgenerate
endmodule // tltp_sync

`default_nettype wire

// >>> logic/tltp_top.v
`include "tltp_consts.vh"
`default_nettype none

// Contract
// - Torque control always uses the primary limit in both directions.
// - Mode 1 applies the primary limit forward and reverse.
// - Mode 3 picks primary or secondary per direction by its limit select.
// - Mode 4 in speed control takes minimum with network values 1 and 2.
// - Mode 5 in speed control takes that minimum only while select is on.
// - Forward select is on when pin or network forward flag is on.
// - Torque feed-forward is enabled only in speed control.
// - Prohibit mode 0 decelerates and stops by the chosen stop sequence.
// - Prohibit mode 0 raises alarm 38 when both prohibit inputs open.
// - Prohibit mode 1 ignores both prohibit inputs.
// - Prohibit mode 2 raises alarm 38 when either input opens.
module tltp_top (
   input wire clk,
   input wire arst_n,
   input wire [1:0] ctrlMode,
   input wire [2:0] torqueLimitModeIn,
   input wire [1:0] travelProhibitModeIn,
   input wire [`TLTP_TW-1:0] primaryTorqueLimit,
   input wire [`TLTP_TW-1:0] secondaryTorqueLimit,
   input wire [`TLTP_TW-1:0] netOptValue1,
   input wire [`TLTP_TW-1:0] netOptValue2,
   input wire [`TLTP_SW-1:0] prohibitStopSequenceSelect,
   input wire fwdLimitSelectPin,
   input wire revLimitSelectPin,
   input wire netFwdLimitFlag,
   input wire netRevLimitFlag,
   input wire fwdTravelBlockIn,
   input wire revTravelBlockIn,
   input wire alarmClear,
   output reg [`TLTP_TW-1:0] fwdTorqueLimit,
   output reg [`TLTP_TW-1:0] revTorqueLimit,
   output reg torqueFfEnable,
   output reg fwdLimitSelect,
   output reg revLimitSelect,
   output reg fwdStopReq,
   output reg revStopReq,
   output reg [`TLTP_SW-1:0] stopSequence,
   output reg prohibitAlarm,
   output reg [7:0] alarmCode,
   output reg [2:0] torqueLimitMode,
   output reg [1:0] travelProhibitMode,
   output reg modeSettingRejected
);
   // Pin inputs cross into the clock domain first
   wire [1:0] selSync;
   wire [1:0] blockSync;
   wire fwdSelPinS;
   wire revSelPinS;
   wire fwdClosed;
   wire revClosed;

   tltp_sync #(
      .WIDTH(2),
      .RST_VAL(`TLTP_SYNC_RST)
   ) uSelSync (
      .clk(clk),
      .arst_n(arst_n),
      .asyncIn({revLimitSelectPin, fwdLimitSelectPin}),
      .syncOut(selSync)
   );

   // Travel pins clear to the closed level, so reset alone raises no prohibit alarm
   tltp_sync #(
      .WIDTH(2),
      .RST_VAL(`TLTP_PIN_IDLE)
   ) uBlockSync (
      .clk(clk),
      .arst_n(arst_n),
      .asyncIn({revTravelBlockIn, fwdTravelBlockIn}),
      .syncOut(blockSync)
   );

   assign fwdSelPinS = selSync[0];
   assign revSelPinS = selSync[1];
   assign fwdClosed = blockSync[0];
   assign revClosed = blockSync[1];

   // Combined limit selects
   wire fwdSelOn;
   wire revSelOn;
   assign fwdSelOn = fwdSelPinS | netFwdLimitFlag;
   assign revSelOn = revSelPinS | netRevLimitFlag;

   // Network-limited candidates
   wire [`TLTP_TW-1:0] fwdNetMin;
   wire [`TLTP_TW-1:0] revNetMin;

   tltp_min #(
      .WIDTH(`TLTP_TW)
   ) uFwdMin (
      .a(primaryTorqueLimit),
      .b(netOptValue1),
      .smaller(fwdNetMin)
   );

   tltp_min #(
      .WIDTH(`TLTP_TW)
   ) uRevMin (
      .a(secondaryTorqueLimit),
      .b(netOptValue2),
      .smaller(revNetMin)
   );

   // Mode settings: out-of-range writes keep the previous value
   wire tlmValid;
   wire tpmValid;
   assign tlmValid = (torqueLimitModeIn >= `TLTP_TLM_MIN) &&
                     (torqueLimitModeIn <= `TLTP_TLM_MAX);
   assign tpmValid = (travelProhibitModeIn <= `TLTP_TPM_MAX);

   reg [2:0] next_torqueLimitMode;
   reg [1:0] next_travelProhibitMode;

   always @*
   begin
      next_torqueLimitMode = torqueLimitMode;
      next_travelProhibitMode = travelProhibitMode;
      if (tlmValid)
      begin
         next_torqueLimitMode = torqueLimitModeIn;
      end
      if (tpmValid)
      begin
         next_travelProhibitMode = travelProhibitModeIn;
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         torqueLimitMode <= `TLTP_TLM_DEFAULT;
         travelProhibitMode <= `TLTP_TPM_DEFAULT;
         modeSettingRejected <= 1'b0;
      end
      else
      begin
         torqueLimitMode <= next_torqueLimitMode;
         travelProhibitMode <= next_travelProhibitMode;
         modeSettingRejected <= ~tlmValid | ~tpmValid;
      end
   end

   // Torque limit selection
   // Torque control overrides the mode; modes 4 and 5 act only in speed control
   reg [`TLTP_TW-1:0] next_fwdTorqueLimit;
   reg [`TLTP_TW-1:0] next_revTorqueLimit;
   wire isSpeed;
   wire isTorque;
   assign isSpeed = (ctrlMode == `TLTP_CM_SPD);
   assign isTorque = (ctrlMode == `TLTP_CM_TRQ);

   always @*
   begin
      next_fwdTorqueLimit = primaryTorqueLimit;
      next_revTorqueLimit = secondaryTorqueLimit;
      if (isTorque)
      begin
         next_fwdTorqueLimit = primaryTorqueLimit;
         next_revTorqueLimit = primaryTorqueLimit;
      end
      else
      begin
         case (torqueLimitMode)
            `TLTP_TLM_PRI_BOTH:
            begin
               next_fwdTorqueLimit = primaryTorqueLimit;
               next_revTorqueLimit = primaryTorqueLimit;
            end
            `TLTP_TLM_PRI_SEC:
            begin
               next_fwdTorqueLimit = primaryTorqueLimit;
               next_revTorqueLimit = secondaryTorqueLimit;
            end
            `TLTP_TLM_INPUT_SW:
            begin
               next_fwdTorqueLimit = fwdSelOn ? secondaryTorqueLimit
                                              : primaryTorqueLimit;
               next_revTorqueLimit = revSelOn ? secondaryTorqueLimit
                                              : primaryTorqueLimit;
            end
            `TLTP_TLM_NET_MIN:
            begin
               next_fwdTorqueLimit = isSpeed ? fwdNetMin : primaryTorqueLimit;
               next_revTorqueLimit = isSpeed ? revNetMin : secondaryTorqueLimit;
            end
            `TLTP_TLM_NET_SW:
            begin
               next_fwdTorqueLimit = (isSpeed && fwdSelOn) ? fwdNetMin
                                                           : primaryTorqueLimit;
               next_revTorqueLimit = (isSpeed && revSelOn) ? revNetMin
                                                           : secondaryTorqueLimit;
            end
            default:
            begin
               next_fwdTorqueLimit = primaryTorqueLimit;
               next_revTorqueLimit = primaryTorqueLimit;
            end
         endcase
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fwdTorqueLimit <= {`TLTP_TW{1'b0}};
         revTorqueLimit <= {`TLTP_TW{1'b0}};
         torqueFfEnable <= 1'b0;
         fwdLimitSelect <= 1'b0;
         revLimitSelect <= 1'b0;
      end
      else
      begin
         fwdTorqueLimit <= next_fwdTorqueLimit;
         revTorqueLimit <= next_revTorqueLimit;
         torqueFfEnable <= isSpeed;
         fwdLimitSelect <= fwdSelOn;
         revLimitSelect <= revSelOn;
      end
   end

   // Travel prohibit handling
   wire fwdOpen;
   wire revOpen;
   assign fwdOpen = (fwdClosed != `TLTP_PIN_IDLE);
   assign revOpen = (revClosed != `TLTP_PIN_IDLE);

   reg next_fwdStopReq;
   reg next_revStopReq;
   reg alarmEvent;

   always @*
   begin
      next_fwdStopReq = 1'b0;
      next_revStopReq = 1'b0;
      alarmEvent = 1'b0;
      case (travelProhibitMode)
         `TLTP_TPM_STOP:
         begin
            next_fwdStopReq = fwdOpen;
            next_revStopReq = revOpen;
            alarmEvent = fwdOpen & revOpen;
         end
         `TLTP_TPM_IGNORE:
         begin
            next_fwdStopReq = 1'b0;
            next_revStopReq = 1'b0;
            alarmEvent = 1'b0;
         end
         `TLTP_TPM_ALARM:
         begin
            alarmEvent = fwdOpen | revOpen;
         end
         default:
         begin
            alarmEvent = 1'b0;
         end
      endcase
   end

   // Alarm latches; a new event wins over a clear in the same cycle
   reg next_prohibitAlarm;
   reg [7:0] next_alarmCode;

   always @*
   begin
      next_prohibitAlarm = prohibitAlarm;
      next_alarmCode = alarmCode;
      if (alarmEvent)
      begin
         next_prohibitAlarm = 1'b1;
         next_alarmCode = `TLTP_ALARM_CODE;
      end
      else if (alarmClear)
      begin
         next_prohibitAlarm = 1'b0;
         next_alarmCode = `TLTP_ALARM_NONE;
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fwdStopReq <= 1'b0;
         revStopReq <= 1'b0;
         stopSequence <= {`TLTP_SW{1'b0}};
         prohibitAlarm <= 1'b0;
         alarmCode <= `TLTP_ALARM_NONE;
      end
      else
      begin
         fwdStopReq <= next_fwdStopReq;
         revStopReq <= next_revStopReq;
         stopSequence <= prohibitStopSequenceSelect;
         prohibitAlarm <= next_prohibitAlarm;
         alarmCode <= next_alarmCode;
      end
   end
endmodule // tltp_top

`default_nettype wire

// >>> test/tb_torque_limit_and_travel_prohibit.sv
`include "tltp_consts.vh"
`default_nettype none
module tb_torque_limit_and_travel_prohibit;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] PRI = 16'h0300, SEC = 16'h0500, N1 = 16'h0200, N2 = 16'h0400;
   logic clk, arst_n, clr;
   logic [1:0] cm, tpmIn;
   logic [2:0] tlmIn;
   logic [3:0] stopSel;
   wire [15:0] n1, n2, fLim, rLim;
   wire nf, nr, pf, pr, fb, rb, ffe, fSel, rSel, fStop, rStop, alarm, rej;
   wire [3:0] stopSeq;
   wire [7:0] code;
   wire [2:0] tlm;
   wire [1:0] tpm;
   integer miscompares, n_checks;
   tltp_far_model far (.netOptValue1(n1), .netOptValue2(n2), .netFwdLimitFlag(nf),
      .netRevLimitFlag(nr), .fwdLimitSelectPin(pf), .revLimitSelectPin(pr),
      .fwdTravelBlockIn(fb), .revTravelBlockIn(rb));
   tltp_top dut (.clk(clk), .arst_n(arst_n), .ctrlMode(cm), .torqueLimitModeIn(tlmIn),
      .travelProhibitModeIn(tpmIn), .primaryTorqueLimit(PRI), .secondaryTorqueLimit(SEC),
      .netOptValue1(n1), .netOptValue2(n2), .prohibitStopSequenceSelect(stopSel),
      .fwdLimitSelectPin(pf), .revLimitSelectPin(pr), .netFwdLimitFlag(nf),
      .netRevLimitFlag(nr), .fwdTravelBlockIn(fb), .revTravelBlockIn(rb), .alarmClear(clr),
      .fwdTorqueLimit(fLim), .revTorqueLimit(rLim), .torqueFfEnable(ffe),
      .fwdLimitSelect(fSel), .revLimitSelect(rSel), .fwdStopReq(fStop), .revStopReq(rStop),
      .stopSequence(stopSeq), .prohibitAlarm(alarm), .alarmCode(code),
      .torqueLimitMode(tlm), .travelProhibitMode(tpm), .modeSettingRejected(rej));
   task chk(input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task pulse_clear;
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(1);
   endtask
   function logic [15:0] ef(input logic [2:0] m, input logic [1:0] c, input logic s, r);
      logic [15:0] b, n;
      b = r ? SEC : PRI;
      n = r ? N2 : N1;
      if (c == `TLTP_CM_TRQ || m == 3'h1) return PRI;
      if (m == 3'h3) return s ? SEC : PRI;
      if (c == `TLTP_CM_SPD && (m == 3'h4 || (m == 3'h5 && s))) return n < b ? n : b;
      return b;
   endfunction
   task t_reset;
      chk(tlm, 3'h1);
      chk(tpm, 2'h0);
      tick(4);
      chk({alarm, code}, 9'h000);
      far.block(1'b0, 1'b0);
      tick(4);
      chk(code, 8'h26);
      arst_n = 1'b0;
      tick(2);
      chk({alarm, code}, 9'h000);
      far.block(1'b1, 1'b1);
      arst_n = 1'b1;
      tick(4);
      chk(code, 8'h00);
      chk(tlm, 3'h1);
      pulse_clear;
      chk(alarm, 1'b0);
   endtask
   task t_reject;
      tlmIn = 3'h5;
      tpmIn = 2'h2;
      tick(2);
      tlmIn = 3'h0;
      tpmIn = 2'h3;
      tick(1);
      chk(rej, 1'b1);
      chk(tpm, 2'h2);
      tlmIn = 3'h6;
      tick(1);
      chk(tlm, 3'h5);
      tlmIn = 3'h1;
      tpmIn = 2'h0;
      tick(2);
      chk(rej, 1'b0);
   endtask
   task t_limits;
      logic p, q;
      for (int c = 0; c < 3; c++)
         for (int m = 1; m < 6; m++)
            for (int j = 0; j < 4; j++)
            begin
               p = j[0] & j[1];
               q = j[0] & !j[1];
               cm = c[1:0];
               tlmIn = m[2:0];
               far.sel(p, q, q, p);
               tick(4);
               chk(fLim, ef(m[2:0], c[1:0], j[0], 1'b0));
               chk(rLim, ef(m[2:0], c[1:0], j[0], 1'b1));
               chk({fSel, rSel}, {2{j[0]}});
               chk(ffe, c == 1);
            end
      far.sel(1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   task t_prohibit;
      stopSel = 4'h9;
      far.block(1'b0, 1'b1);
      tick(4);
      chk({fStop, rStop, alarm}, 3'b100);
      chk(stopSeq, 4'h9);
      far.block(1'b0, 1'b0);
      tick(4);
      chk({rStop, code}, {1'b1, 8'h26});
      far.block(1'b1, 1'b1);
      tick(4);
      pulse_clear;
      chk(alarm, 1'b0);
      tpmIn = 2'h1;
      tick(2);
      far.block(1'b0, 1'b0);
      tick(4);
      chk({fStop, rStop, alarm}, 3'b000);
      far.block(1'b1, 1'b0);
      tpmIn = 2'h2;
      tick(4);
      chk({rStop, alarm, code}, {2'b01, 8'h26});
      far.block(1'b1, 1'b1);
      tpmIn = 2'h0;
      tick(4);
      pulse_clear;
      chk({alarm, code}, 9'h000);
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      miscompares = 0;
      n_checks = 0;
      {arst_n, clr, cm, tpmIn, stopSel} = '0;
      tlmIn = 3'h1;
      tick(6);
      arst_n = 1'b1;
      t_reset;
      t_reject;
      t_limits;
      t_prohibit;
      results;
   end
   initial
   begin
      #100us;
      miscompares++;
      results;
   end
endmodule // tb_torque_limit_and_travel_prohibit
`default_nettype wire

// >>> test/tltp_assertions.sv
`default_nettype none
module tltp_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [1:0] ctrlMode,
   input wire logic [2:0] torqueLimitModeIn,
   input wire logic [15:0] primaryTorqueLimit,
   input wire logic [15:0] secondaryTorqueLimit,
   input wire logic [15:0] netOptValue1,
   input wire logic netFwdLimitFlag,
   input wire logic fwdTravelBlockIn,
   input wire logic revTravelBlockIn,
   input wire logic [15:0] fwdTorqueLimit,
   input wire logic [15:0] revTorqueLimit,
   input wire logic torqueFfEnable,
   input wire logic fwdLimitSelect,
   input wire logic fwdStopReq,
   input wire logic revStopReq,
   input wire logic prohibitAlarm,
   input wire logic [7:0] alarmCode,
   input wire logic [2:0] torqueLimitMode,
   input wire logic [1:0] travelProhibitMode,
   input wire logic modeSettingRejected
);
   logic [1:0] up;
   wire rdy = up == 2'h3;
   wire spd = ctrlMode == 2'h1;
   function automatic logic [15:0] mn(input logic [15:0] a, b);
      return a < b ? a : b;
   endfunction
   // Checks other than a_alm and a_ign are held off for the first three edges after reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         up <= 2'h0;
      else if (!rdy)
         up <= up + 2'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_trq;
      rdy && ctrlMode == 2'h2 |=> fwdTorqueLimit == $past(primaryTorqueLimit)
         && revTorqueLimit == $past(primaryTorqueLimit);
   endproperty
   a_trq: assert property (p_trq) else $error("torque mode limit");
   property p_m3;
      rdy && torqueLimitMode == 3'h3 && ctrlMode != 2'h2 |=> fwdTorqueLimit ==
         (fwdLimitSelect ? $past(secondaryTorqueLimit) : $past(primaryTorqueLimit));
   endproperty
   a_m3: assert property (p_m3) else $error("switched limit");
   property p_m4;
      rdy && torqueLimitMode == 3'h4 && spd |=>
         fwdTorqueLimit == mn($past(primaryTorqueLimit), $past(netOptValue1));
   endproperty
   a_m4: assert property (p_m4) else $error("min limit");
   property p_fsel;
      rdy && netFwdLimitFlag |=> fwdLimitSelect;
   endproperty
   a_fsel: assert property (p_fsel) else $error("fwd select");
   property p_ffe;
      rdy |=> torqueFfEnable == $past(spd);
   endproperty
   a_ffe: assert property (p_ffe) else $error("feed-forward enable");
   property p_alm;
      (travelProhibitMode == 2'h0 && !fwdTravelBlockIn && !revTravelBlockIn)[*4]
         |-> prohibitAlarm && alarmCode == 8'h26;
   endproperty
   a_alm: assert property (p_alm) else $error("prohibit alarm");
   property p_ign;
      (travelProhibitMode == 2'h1)[*2] |-> !fwdStopReq && !revStopReq;
   endproperty
   a_ign: assert property (p_ign) else $error("ignored inputs");
   property p_rej;
      rdy && (torqueLimitModeIn == 3'h0 || torqueLimitModeIn > 3'h5) |=>
         modeSettingRejected && $stable(torqueLimitMode);
   endproperty
   a_rej: assert property (p_rej) else $error("bad mode taken");
   c_alm: cover property (prohibitAlarm);
   c_m5: cover property (torqueLimitMode == 3'h5 && fwdLimitSelect);
   c_rej: cover property (modeSettingRejected);
endmodule // tltp_chk
bind tltp_top tltp_chk u_chk (.clk, .arst_n, .ctrlMode, .torqueLimitModeIn,
   .primaryTorqueLimit, .secondaryTorqueLimit, .netOptValue1, .netFwdLimitFlag,
   .fwdTravelBlockIn, .revTravelBlockIn, .fwdTorqueLimit, .revTorqueLimit,
   .torqueFfEnable, .fwdLimitSelect, .fwdStopReq, .revStopReq, .prohibitAlarm,
   .alarmCode, .torqueLimitMode, .travelProhibitMode, .modeSettingRejected);
`default_nettype wire

// >>> test/tltp_far_model.sv
`default_nettype none
module tltp_far_model (
   output logic [15:0] netOptValue1,
   output logic [15:0] netOptValue2,
   output logic netFwdLimitFlag,
   output logic netRevLimitFlag,
   output logic fwdLimitSelectPin,
   output logic revLimitSelectPin,
   output logic fwdTravelBlockIn,
   output logic revTravelBlockIn
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      netOptValue1 = 16'h0200;
      netOptValue2 = 16'h0400;
      sel(1'b0, 1'b0, 1'b0, 1'b0);
      block(1'b1, 1'b1);
   end
   task sel(input logic pf, nf, pr, nr);
      fwdLimitSelectPin = pf;
      netFwdLimitFlag = nf;
      revLimitSelectPin = pr;
      netRevLimitFlag = nr;
   endtask
   // Travel switches read high while closed
   task block(input logic f, r);
      fwdTravelBlockIn = f;
      revTravelBlockIn = r;
   endtask
endmodule // tltp_far_model
`default_nettype wire
